/* File: logic/dma_request_ack_interface.sv */
// dma request, acknowledge and end-of-process interface
//
// Decided for this implementation: the plain strobed port and the placing of the registers.
`default_nettype none
module dma_request_ack_interface (
  input wire logic mclk_i,
  input wire logic sys_rst_i,
  input wire logic [7:0] channel_service_request_i,
  input wire logic shared_channel4_request_pin_i,
  input wire logic shared_channel4_pin_oe_i,
  input wire logic end_of_process_line_i,
  input wire logic bus_hold_acknowledge_i,
  input wire dma_req_pkg::reg_req_t reg_req_i,
  output logic [31:0] reg_rdata_o,
  output logic hold_request_o,
  output logic [2:0] encoded_channel_acknowledge_o,
  output logic end_of_process_line_o,
  output logic end_of_process_line_oe_o,
  output logic interrupt_request_nine_o,
  output logic irq_o
);
  import dma_req_pkg::*;

  logic [7:0] req_raw;
  logic [7:0] req_sync;
  logic eop_n_sync;
  logic eop_n_async_reg;
  logic eop_n_sel;
  logic [2:0] ctrl_reg;
  logic [7:0] dma_mask_reg;
  logic [7:0] swreq_reg;
  logic [st_w-1:0] status_reg;
  logic [st_w-1:0] status_set;
  logic [st_w-1:0] irq_mask_reg;
  logic [15:0] count_reg;
  logic [15:0] remain_reg;
  logic [7:0] eligible;
  logic any_req;
  logic [2:0] win_ch;
  logic [2:0] act_ch_reg;
  logic act_valid_reg;
  dma_state_t state_reg;
  logic interrupt_request_nine_sync_d_reg;
  logic interrupt_request_nine_pend_reg;
  logic interrupt_request_nine_active;
  logic last_access;
  logic eop_ext;

  // pad with pull-up: undriven pin reads high
  always_comb begin
    req_raw = channel_service_request_i;
    req_raw[ch4] = shared_channel4_pin_oe_i ? shared_channel4_request_pin_i
                                            : 1'b1;
  end

  // all sync on mclk_i
  // channel 4 idles high after reset, so no false irq nine edge
  dma_sync2 #(.width(num_ch), .rst_val(8'h01 << ch4)) u_req_sync (
    .mclk_i(mclk_i),
    .sys_rst_i(sys_rst_i),
    .d_i(req_raw),
    .q_o(req_sync)
  );

  dma_sync2 #(.width(1), .rst_val(1'b1)) u_eop_sync (
    .mclk_i(mclk_i),
    .sys_rst_i(sys_rst_i),
    .d_i(end_of_process_line_i),
    .q_o(eop_n_sync)
  );

  // async mode: one extra stage after sync, sync mode: synchroniser output
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      eop_n_async_reg <= 1'b1;
    end else begin
      eop_n_async_reg <= eop_n_sync;
    end
  end
  assign eop_n_sel = ctrl_reg[ctrl_eop_sync] ? eop_n_sync
                                             : eop_n_async_reg;
  // external end only counts while we are not driving the line
  assign eop_ext = !eop_n_sel && !end_of_process_line_oe_o
                   && (state_reg == st_req || state_reg == st_tgt);

  // dma path masked apart from irq path
  assign eligible = (req_sync | swreq_reg) & ~dma_mask_reg;

  dma_prio u_prio (
    .req_i(eligible),
    .any_o(any_req),
    .ch_o(win_ch)
  );

  assign last_access = (remain_reg == 16'h0001);

  // transfer sequencing
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      state_reg <= st_idle;
      act_ch_reg <= 3'h0;
      act_valid_reg <= 1'b0;
      remain_reg <= 16'h0000;
    end else begin
      unique case (state_reg)
        st_idle: begin
          if (any_req) begin
            act_ch_reg <= win_ch;
            act_valid_reg <= 1'b1;
            remain_reg <= count_reg;
            state_reg <= st_hold;
          end
        end
        st_hold: begin
          if (bus_hold_acknowledge_i) begin
            state_reg <= st_req;
          end
        end
        st_req: begin
          state_reg <= eop_ext ? st_done : st_tgt;
        end
        st_tgt: begin
          if (eop_ext || last_access) begin
            state_reg <= st_done;
          end else begin
            remain_reg <= remain_reg - 16'h0001;
            state_reg <= st_req;
          end
        end
        st_done: begin
          act_valid_reg <= 1'b0;
          state_reg <= st_idle;
        end
      endcase
    end
  end

  // pin outputs
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      hold_request_o <= 1'b0;
      encoded_channel_acknowledge_o <= ack_idle;
      end_of_process_line_o <= 1'b1;
      end_of_process_line_oe_o <= 1'b0;
    end else begin
      hold_request_o <= (state_reg == st_idle && any_req)
                        || state_reg == st_hold
                        || state_reg == st_req
                        || state_reg == st_tgt;
      // channel 4 never gets a code; st_tgt gives idle
      if (((state_reg == st_hold && bus_hold_acknowledge_i)
          || (state_reg == st_tgt && !eop_ext && !last_access))
          && act_ch_reg != 3'(ch4)) begin
        encoded_channel_acknowledge_o <= act_ch_reg;
      end else begin
        encoded_channel_acknowledge_o <= ack_idle;
      end
      // low through the requester access that is the last one
      if ((state_reg == st_hold && bus_hold_acknowledge_i
           && count_reg == 16'h0001)
          || (state_reg == st_tgt && !eop_ext
              && remain_reg == 16'h0002)) begin
        end_of_process_line_o <= 1'b0;
        end_of_process_line_oe_o <= 1'b1;
      end else begin
        end_of_process_line_o <= 1'b1;
        end_of_process_line_oe_o <= 1'b0;
      end
    end
  end

  // interrupt nine, active low pin, edge or level
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      interrupt_request_nine_sync_d_reg <= 1'b1;
      interrupt_request_nine_pend_reg <= 1'b0;
    end else begin
      interrupt_request_nine_sync_d_reg <= req_sync[ch4];
      if (interrupt_request_nine_sync_d_reg && !req_sync[ch4]) begin
        interrupt_request_nine_pend_reg <= 1'b1;
      end else if (req_sync[ch4]) begin
        interrupt_request_nine_pend_reg <= 1'b0;
      end
    end
  end
  assign interrupt_request_nine_active = ctrl_reg[ctrl_interrupt_request_nine_level] ? !req_sync[ch4]
                                                 : interrupt_request_nine_pend_reg;

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      interrupt_request_nine_o <= 1'b0;
    end else begin
      interrupt_request_nine_o <= interrupt_request_nine_active
                                  && !ctrl_reg[ctrl_interrupt_request_nine_mask];
    end
  end

  // status events
  always_comb begin
    status_set = '0;
    status_set[st_tc] = state_reg == st_tgt && last_access && !eop_ext;
    status_set[st_eop_ext] = eop_ext;
    status_set[st_interrupt_request_nine] = interrupt_request_nine_active && !ctrl_reg[ctrl_interrupt_request_nine_mask];
    status_set[st_grant] = state_reg == st_hold && bus_hold_acknowledge_i;
  end

  // register writes
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      ctrl_reg <= 3'h0;
      dma_mask_reg <= dma_mask_rst;
      irq_mask_reg <= '0;
      count_reg <= count_rst;
      swreq_reg <= 8'h00;
    end else begin
      if (state_reg == st_done) begin
        swreq_reg[act_ch_reg] <= 1'b0;
      end
      if (reg_req_i.wr) begin
        unique case (reg_req_i.addr)
          reg_ctrl: ctrl_reg <= reg_req_i.wdata[2:0];
          reg_dma_mask: dma_mask_reg <= reg_req_i.wdata[7:0];
          reg_irq_mask: irq_mask_reg <= reg_req_i.wdata[st_w-1:0];
          reg_count: count_reg <= reg_req_i.wdata[15:0];
          reg_swreq: swreq_reg <= swreq_reg | reg_req_i.wdata[7:0];
          default: ;
        endcase
      end
    end
  end

  // sticky status, set wins over write-one-to-clear
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      status_reg <= '0;
    end else if (reg_req_i.wr && reg_req_i.addr == reg_status) begin
      status_reg <= (status_reg & ~reg_req_i.wdata[st_w-1:0]) | status_set;
    end else begin
      status_reg <= status_reg | status_set;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |((status_reg | status_set) & ~irq_mask_reg);
    end
  end

  // read data, one cycle after strobe, zero otherwise
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      reg_rdata_o <= 32'h0;
    end else if (reg_req_i.rd) begin
      unique case (reg_req_i.addr)
        reg_ctrl: reg_rdata_o <= {29'h0, ctrl_reg};
        reg_dma_mask: reg_rdata_o <= {24'h0, dma_mask_reg};
        reg_status: reg_rdata_o <= {28'h0, status_reg};
        reg_irq_mask: reg_rdata_o <= {28'h0, irq_mask_reg};
        reg_count: reg_rdata_o <= {16'h0, count_reg};
        reg_active: reg_rdata_o <= {4'h0, remain_reg[10:0], state_reg,
                                    req_sync, act_valid_reg, act_ch_reg};
        reg_swreq: reg_rdata_o <= {24'h0, swreq_reg};
        default: reg_rdata_o <= 32'h0;
      endcase
    end else begin
      reg_rdata_o <= 32'h0;
    end
  end
endmodule : dma_request_ack_interface
`default_nettype wire

/* File: logic/dma_req_pkg.sv */
// package: constants and types for the dma request/acknowledge block
`default_nettype none
package dma_req_pkg;
  localparam int num_ch = 8;
  localparam int ch4 = 4;
  localparam logic [2:0] ack_idle = 3'h4;
  // register indices (byte address = index * 4)
  localparam logic [3:0] reg_ctrl = 4'h0;
  localparam logic [3:0] reg_dma_mask = 4'h1;
  localparam logic [3:0] reg_status = 4'h2;
  localparam logic [3:0] reg_irq_mask = 4'h3;
  localparam logic [3:0] reg_count = 4'h4;
  localparam logic [3:0] reg_active = 4'h5;
  localparam logic [3:0] reg_swreq = 4'h6;
  // ctrl fields
  localparam int ctrl_interrupt_request_nine_level = 0;
  localparam int ctrl_eop_sync = 1;
  localparam int ctrl_interrupt_request_nine_mask = 2;
  // status bits
  localparam int st_tc = 0;
  localparam int st_eop_ext = 1;
  localparam int st_interrupt_request_nine = 2;
  localparam int st_grant = 3;
  localparam int st_w = 4;
  localparam logic [7:0] dma_mask_rst = 8'h10;
  localparam logic [15:0] count_rst = 16'h0003;
  typedef enum logic [4:0] {
    st_idle = 5'b00001,
    st_hold = 5'b00010,
    st_req = 5'b00100,
    st_tgt = 5'b01000,
    st_done = 5'b10000
  } dma_state_t;
  typedef struct packed {
    logic [3:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;
endpackage : dma_req_pkg
`default_nettype wire

/* File: logic/dma_sync2.sv */
// two flip-flop synchroniser bank
`default_nettype none
module dma_sync2 #(
  parameter int width = 1,
  parameter logic [width-1:0] rst_val = '0
) (
  input wire logic mclk_i,
  input wire logic sys_rst_i,
  input wire logic [width-1:0] d_i,
  output logic [width-1:0] q_o
);
  logic [width-1:0] meta_reg;
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      meta_reg <= rst_val;
      q_o <= rst_val;
    end else begin
      meta_reg <= d_i;
      q_o <= meta_reg;
    end
  end
endmodule : dma_sync2
`default_nettype wire

/* File: logic/dma_prio.sv */
// fixed priority resolver, lowest index wins
`default_nettype none
module dma_prio (
  input wire logic [7:0] req_i,
  output logic any_o,
  output logic [2:0] ch_o
);
  always_comb begin
    any_o = 1'b0;
    ch_o = 3'h0;
    for (int i = 7; i >= 0; i--) begin
      if (req_i[i]) begin
        any_o = 1'b1;
        ch_o = 3'(i);
      end
    end
  end
endmodule : dma_prio
`default_nettype wire

/* File: verif/dma_periph_model.sv */
// far-side model: bus master hold answer, pin pull-ups
`default_nettype none
module dma_periph_model (
  input wire logic mclk_i,
  input wire logic hold_i,
  input wire logic eop_drv_i,
  input wire logic eop_oe_i,
  input wire logic ext_eop_i,
  input wire logic slow_i,
  input wire logic pin_lvl_i,
  input wire logic pin_oe_i,
  output logic bus_hold_acknowledge_o,
  output logic eop_line_o,
  output logic pin_o
);
  logic [2:0] hold_d;
  always_ff @(posedge mclk_i) begin
    hold_d <= {hold_d[1:0], hold_i};
  end
  // answer after one or three cycles; slow answer drops with hold, fast one a cycle later
  assign bus_hold_acknowledge_o = slow_i ? hold_d[2] & hold_i : hold_d[0];
  // open pin reads high
  assign pin_o = pin_oe_i ? pin_lvl_i : 1'b1;
  // wired low of both parties over a pull-up
  assign eop_line_o = !(eop_oe_i && !eop_drv_i) && !ext_eop_i;
endmodule : dma_periph_model
`default_nettype wire

/* File: verif/dma_request_ack_interface_chk.sv */
// checker: port-level assertions for the dma request block
`default_nettype none
module dma_request_ack_interface_chk
  import dma_req_pkg::*;
(
  input wire logic mclk_i,
  input wire logic sys_rst_i,
  input wire logic [7:0] channel_service_request_i,
  input wire logic shared_channel4_request_pin_i,
  input wire logic shared_channel4_pin_oe_i,
  input wire logic end_of_process_line_i,
  input wire logic bus_hold_acknowledge_i,
  input wire dma_req_pkg::reg_req_t reg_req_i,
  input wire logic [31:0] reg_rdata_o,
  input wire logic hold_request_o,
  input wire logic [2:0] encoded_channel_acknowledge_o,
  input wire logic end_of_process_line_o,
  input wire logic end_of_process_line_oe_o,
  input wire logic interrupt_request_nine_o,
  input wire logic irq_o
);
  wire logic [2:0] ack = encoded_channel_acknowledge_o;
  wire logic pin = !shared_channel4_pin_oe_i | shared_channel4_request_pin_i;
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (sys_rst_i);
  ack_in_hold_a: assert property (ack != ack_idle |-> hold_request_o)
    else $error("acknowledge outside hold");
  ack_pulse_a: assert property (ack != ack_idle |=> ack == ack_idle)
    else $error("target access not idle code");
  ack_after_bus_hold_acknowledge_a: assert property (ack != ack_idle |-> $past(bus_hold_acknowledge_i))
    else $error("access without hold acknowledge");
  eop_low_a: assert property (end_of_process_line_oe_o |-> !end_of_process_line_o)
    else $error("end of process driven high");
  eop_in_xfer_a: assert property (end_of_process_line_oe_o |-> hold_request_o)
    else $error("end of process outside transfer");
  rdata_idle_a: assert property (!$past(reg_req_i.rd) |-> reg_rdata_o == '0)
    else $error("read data outside read answer");
  reset_idle_a: assert property ($fell(sys_rst_i) |-> !hold_request_o && ack == ack_idle)
    else $error("outputs not idle after reset");
  interrupt_request_nine_high_pin_a: assert property (pin [*5] |-> !interrupt_request_nine_o)
    else $error("irq nine with pin high");
  cover property (ack != ack_idle);
  cover property (end_of_process_line_oe_o);
  cover property (irq_o);
endmodule : dma_request_ack_interface_chk
bind dma_request_ack_interface dma_request_ack_interface_chk u_chk (.*);
`default_nettype wire

/* File: verif/dma_request_ack_interface_tb.sv */
// testbench for the dma request/acknowledge block
`default_nettype none
module dma_request_ack_interface_tb;
  import dma_req_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk_i, sys_rst_i, pin_lvl, pin_oe, ext, slow, bus_hold_acknowledge, eopl, pin;
  logic [7:0] want;
  reg_req_t req;
  logic [31:0] rdata;
  logic hold, eop_d, eop_oe, interrupt_request_nine, irq;
  logic [2:0] ack;
  int n_mismatch = 0;
  int num_checks = 0;
  dma_request_ack_interface u_dma_request_ack_interface (
    .mclk_i(mclk_i), .sys_rst_i(sys_rst_i),
    .channel_service_request_i(want),
    .shared_channel4_request_pin_i(pin), .shared_channel4_pin_oe_i(pin_oe),
    .end_of_process_line_i(eopl), .bus_hold_acknowledge_i(bus_hold_acknowledge),
    .reg_req_i(req), .reg_rdata_o(rdata), .hold_request_o(hold),
    .encoded_channel_acknowledge_o(ack), .end_of_process_line_o(eop_d),
    .end_of_process_line_oe_o(eop_oe), .interrupt_request_nine_o(interrupt_request_nine),
    .irq_o(irq));
  dma_periph_model u_dma_periph_model (
    .mclk_i(mclk_i), .hold_i(hold), .eop_drv_i(eop_d), .eop_oe_i(eop_oe),
    .ext_eop_i(ext), .slow_i(slow), .pin_lvl_i(pin_lvl), .pin_oe_i(pin_oe),
    .bus_hold_acknowledge_o(bus_hold_acknowledge), .eop_line_o(eopl), .pin_o(pin));
  initial begin
    mclk_i = 0;
    forever #50 mclk_i = ~mclk_i;
  end
  task complete_run;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : complete_run
  task chk(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  task wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge mclk_i) req <= '{a, d, 1'b1, 1'b0};
    @(posedge mclk_i) req <= '0;
  endtask : wr
  task rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge mclk_i) req <= '{a, 32'h0, 1'b0, 1'b1};
    @(posedge mclk_i) req <= '0;
    #1 d = rdata;
  endtask : rd
  // wait up to 40 cycles for a level on a design output
  task automatic wait_for(ref logic s, input logic v);
    int n;
    n = 0;
    #1;
    while (s !== v && n < 40) begin
      @(posedge mclk_i) #1 n++;
    end
    chk(s, v);
  endtask : wait_for
  // one single-access transfer; w requesters, e expected code
  task xfer(input logic [7:0] w, input logic [2:0] e);
    logic [31:0] d;
    wr(reg_count, 32'h1);
    wr(reg_dma_mask, {24'h0, ~w});
    want <= w;
    wait_for(hold, 1'b1);
    want <= '0;
    wr(reg_dma_mask, 32'hff);
    wait_for(eop_oe, 1'b1);
    chk(ack, e);
    chk(eop_d, 1'b0);
    @(posedge mclk_i) #1 chk(ack, ack_idle);
    wait_for(hold, 1'b0);
    rd(reg_status, d);
    chk(d[st_tc], 1'b1);
    wr(reg_status, 32'h1f);
  endtask : xfer
  task t_regs;
    logic [31:0] d;
    rd(reg_dma_mask, d);
    chk(d, 32'h10);
    rd(reg_count, d);
    chk(d, 32'h3);
    rd(4'hf, d);
    chk(d, 32'h0);
  endtask : t_regs
  task t_chans;
    for (int c = 0; c < 8; c++) begin
      slow <= (c == 7);
      if (c != 4) xfer(8'h1 << c, c[2:0]);
    end
    xfer(8'h24, 3'h2);
    xfer(8'h81, 3'h0);
  endtask : t_chans
  task t_ch4;
    xfer(8'h10, ack_idle);
  endtask : t_ch4
  task t_interrupt_request_nine;
    wr(reg_irq_mask, 32'h0);
    pin_oe <= 1'b1;
    pin_lvl <= 1'b0;
    repeat (6) @(posedge mclk_i);
    #1 chk(interrupt_request_nine, 1'b1);
    chk(irq, 1'b1);
    wr(reg_irq_mask, 32'h1f);
    @(posedge mclk_i) #1 chk(irq, 1'b0);
    pin_lvl <= 1'b1;
    repeat (6) @(posedge mclk_i);
    #1 chk(interrupt_request_nine, 1'b0);
    wr(reg_ctrl, 32'h1);
    pin_lvl <= 1'b0;
    repeat (6) @(posedge mclk_i);
    #1 chk(interrupt_request_nine, 1'b1);
    wr(reg_ctrl, 32'h5);
    @(posedge mclk_i) #1 chk(interrupt_request_nine, 1'b0);
    pin_lvl <= 1'b1;
    wr(reg_status, 32'h1f);
    wr(reg_irq_mask, 32'h0);
    #1 chk(irq, 1'b0);
  endtask : t_interrupt_request_nine
  task t_eop(input logic s);
    logic [31:0] d;
    wr(reg_ctrl, {30'h0, s, 1'b0});
    wr(reg_count, 32'h3);
    wr(reg_dma_mask, 32'hfe);
    want <= 8'h01;
    wait_for(hold, 1'b1);
    want <= '0;
    wr(reg_dma_mask, 32'hff);
    ext <= 1'b1;
    wait_for(hold, 1'b0);
    ext <= 1'b0;
    rd(reg_status, d);
    chk(d[st_eop_ext], 1'b1);
    wr(reg_status, 32'h1f);
  endtask : t_eop
  initial begin
    repeat (30000) @(posedge mclk_i);
    n_mismatch++;
    complete_run;
  end
  initial begin
    sys_rst_i = 1;
    req = '0;
    want = '0;
    {pin_lvl, pin_oe, ext, slow} = 4'h8;
    repeat (16) @(posedge mclk_i);
    sys_rst_i <= 0;
    @(posedge mclk_i) #1 chk(ack, ack_idle);
    chk(eop_oe, 1'b0);
    t_regs;
    t_chans;
    t_ch4;
    t_interrupt_request_nine;
    t_eop(1'b1);
    t_eop(1'b0);
    complete_run;
  end
endmodule : dma_request_ack_interface_tb
`default_nettype wire
